/* logic/crb_pkg.sv */
// crb_pkg: constants and types for the cursor/auxiliary register bank
// assumes an axi4-lite slave with 32-bit data, byte offsets = 4 * index
package crb_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_ADDR_LOW  = 8'h08;
   localparam logic [7:0] IDX_ADDR_HIGH = 8'h09;
   localparam logic [7:0] IDX_PAT_DATA  = 8'h0a;
   localparam logic [7:0] IDX_C0_RED    = 8'h23;
   localparam logic [7:0] IDX_C0_GREEN  = 8'h24;
   localparam logic [7:0] IDX_C0_BLUE   = 8'h25;
   localparam logic [7:0] IDX_C1_RED    = 8'h26;
   localparam logic [7:0] IDX_C1_GREEN  = 8'h27;
   localparam logic [7:0] IDX_C1_BLUE   = 8'h28;
   localparam logic [7:0] IDX_AUX_CTRL  = 8'h29;

   localparam int ADDR_W    = 12;
   localparam int PTR_W     = 10;
   localparam int ALIGN_W   = 2;
   localparam int IDX_TOP   = 9;
   localparam int LANE_W    = 8;
   // index of an out-of-range or misaligned address; bit 8 is never a real index
   localparam logic [8:0] IDX_NONE = 9'h100;
   localparam int PAT_DEPTH = 1024;
   localparam int COLOR_NUM = 6;

   localparam logic [PTR_W-1:0] PTR_ONE  = 10'h001;
   // aux control reset: zoom 000, reserved 0, self clocked, psel off, window off, complement
   localparam logic [7:0]       AUX_RST  = 8'h09;
   localparam logic [7:0]       AUX_MASK = 8'hef;
   localparam logic [1:0]       RESP_OK  = 2'h0;
   localparam logic [1:0]       RESP_ERR = 2'h2;

   typedef struct packed {
      logic [2:0] hzoom;
      logic       aux_reserved_bit4;
      logic       fb_clock_select;
      logic       port_select_enable;
      logic       aux_window_enable;
      logic       window_complement;
   } crb_aux_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } crb_color_t;

   typedef enum logic [1:0] {
      DEC_NONE,
      DEC_COLOR,
      DEC_OTHER
   } crb_dec_t;

endpackage : crb_pkg

/* logic/crb_regs.sv */
// crb_regs: cursor colours, cursor pattern ram with pointer, aux control byte
// assumes an axi4-lite master with at most one write and one read in flight
// assumes the zoom, windowing and frame buffer logic reads the outputs directly
//
// Summary of operation
// - six 8-bit cursor colour bytes, no reset, host read/write any time
// - colour 0 rgb at 23h-25h, colour 1 rgb at 26h-28h
// - colour bytes hold any value 00 to ff
// - 10-bit pattern pointer: low byte at 08h, two high bits at 09h
// - high pointer byte bits 2-7 always read zero
// - pointer takes 000-3ff, no reset value, loadable any time
// - data port at 0ah reads/writes pattern ram at current pointer
// - four 2-plane pixels per byte, pixel n plane0 bit 2n, plane1 bit 2n+1
// - aux control at 29h, accessible any time, bit7 on data bit7
// - aux bits 7-5 horizontal zoom, reset 0; bit 4 reserved
// - aux bit 3 frame buffer clocking: 0 external, 1 self, reset 1
// - aux bit 2 port-select enable, reset 0
// - aux bit 1 auxiliary window enable, reset 0
// - aux bit 0 window complement, reset 1
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module crb_regs
   import crb_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   // axi4-lite write response
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   // axi4-lite read data
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // to the zoom, windowing and frame buffer datapaths
   output      crb_aux_t          aux_ctrl,
   output      crb_color_t        cursor0_color,
   output      crb_color_t        cursor1_color,
   output      logic [PTR_W-1:0]  cursor_ptr
);

   // map a byte address to a register index; misaligned or out of range -> none
   function automatic logic [8:0] addr_to_idx(input logic [ADDR_W-1:0] a);
      logic [8:0] r;
      r = IDX_NONE;
      if (a[ALIGN_W-1:0] == '0 && a[ADDR_W-1:IDX_TOP+1] == '0)
         r = {1'b0, a[IDX_TOP:ALIGN_W]};
      return r;
   endfunction : addr_to_idx

   function automatic logic known_idx(input logic [8:0] i);
      logic k;
      k = 1'b0;
      if (!i[8])
      begin
         case (i[7:0])
            IDX_ADDR_LOW, IDX_ADDR_HIGH, IDX_PAT_DATA, IDX_C0_RED, IDX_C0_GREEN,
            IDX_C0_BLUE, IDX_C1_RED, IDX_C1_GREEN, IDX_C1_BLUE, IDX_AUX_CTRL:
               k = 1'b1;
            default:
               k = 1'b0;
         endcase
      end
      return k;
   endfunction : known_idx

   // colour decode for an index: DEC_COLOR for a colour byte, or DEC_NONE
   function automatic crb_dec_t color_dec(input logic [8:0] i);
      crb_dec_t d;
      d = DEC_NONE;
      if (!i[8] && i[7:0] >= IDX_C0_RED && i[7:0] <= IDX_C1_BLUE)
         d = DEC_COLOR;
      return d;
   endfunction : color_dec

   // true when a decoded index names one given register
   function automatic logic is_idx(input logic [8:0] i, input logic [7:0] idx);
      logic m;
      m = (i == {1'b0, idx});
      return m;
   endfunction : is_idx

   // slot of a colour byte, 0 to 5 from colour 0 red up
   function automatic logic [2:0] color_slot(input logic [8:0] i);
      logic [7:0] off;
      off = i[7:0] - IDX_C0_RED;
      return off[2:0];
   endfunction : color_slot

   // storage: colours and pattern ram have no reset, as on the real part
   logic [7:0]       color_ff [COLOR_NUM];
   logic [7:0]       pat_ff   [PAT_DEPTH];
   logic [PTR_W-1:0] ptr_ff;
   logic [7:0]       aux_ff;

   // write channel state
   logic              aw_held_ff;
   logic              w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;

   // read channel state
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;

   logic              wr_fire;
   logic [8:0]        wr_idx;
   logic              wr_lane0;
   logic              rd_fire;
   logic [8:0]        rd_idx;
   logic [7:0]        rd_byte;
   logic              pat_wr;
   logic              pat_rd;
   logic              wr_ptr_low;
   logic              wr_ptr_high;
   logic              wr_aux;
   logic              wr_color;

   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   // reads wait out a commit cycle, so a data port read and a data port
   // write never share one pointer step
   assign s_axi_arready = !rvalid_ff && !wr_fire;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // address and data may arrive in either order; commit once both are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
      end
      else if (wr_fire)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
      end
   end

   assign wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_idx   = addr_to_idx(awaddr_ff);
   // registers live in byte lane 0; other lanes are ignored
   assign wr_lane0 = wr_fire && wstrb_ff[0] && known_idx(wr_idx);

   // one strobe per register, one shared by the six colour bytes, all from the single committed write
   assign wr_ptr_low  = wr_lane0 && is_idx(wr_idx, IDX_ADDR_LOW);
   assign wr_ptr_high = wr_lane0 && is_idx(wr_idx, IDX_ADDR_HIGH);
   assign wr_aux      = wr_lane0 && is_idx(wr_idx, IDX_AUX_CTRL);
   assign wr_color    = wr_lane0 && color_dec(wr_idx) == DEC_COLOR;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bvalid_ff <= 1'b0;
      else if (wr_fire)
         bvalid_ff <= 1'b1;
      else if (s_axi_bready)
         bvalid_ff <= 1'b0;
   end

   // refused writes still answer, with an error code
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bresp_ff <= RESP_OK;
      else if (wr_fire)
         bresp_ff <= known_idx(wr_idx) ? RESP_OK : RESP_ERR;
   end

   // colour bytes take any value
   always_ff @(posedge aclk)
   begin
      if (wr_color)
         color_ff[color_slot(wr_idx)] <= wdata_ff[LANE_W-1:0];
   end

   // aux control byte; reserved bit 4 is not stored and reads zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         aux_ff <= AUX_RST;
      else if (wr_aux)
         aux_ff <= wdata_ff[LANE_W-1:0] & AUX_MASK;
   end

   assign pat_wr = wr_lane0 && is_idx(wr_idx, IDX_PAT_DATA);
   assign pat_rd = rd_fire && is_idx(rd_idx, IDX_PAT_DATA);

   // pattern ram at the current pointer; full byte stored
   always_ff @(posedge aclk)
   begin
      if (pat_wr)
         pat_ff[ptr_ff] <= wdata_ff[LANE_W-1:0];
   end

   // pointer: no reset value; only the high byte's low two bits are kept
   always_ff @(posedge aclk)
   begin
      if (wr_ptr_low)
         ptr_ff[LANE_W-1:0] <= wdata_ff[LANE_W-1:0];
      else if (wr_ptr_high)
         ptr_ff[PTR_W-1:LANE_W] <= wdata_ff[PTR_W-LANE_W-1:0];
      else if (pat_wr || pat_rd)
         ptr_ff <= ptr_ff + PTR_ONE;
   end

   // read path: one cycle from address to data
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = addr_to_idx(s_axi_araddr);

   always_comb
   begin
      rd_byte = '0;
      if (color_dec(rd_idx) == DEC_COLOR)
         rd_byte = color_ff[color_slot(rd_idx)];
      else if (is_idx(rd_idx, IDX_ADDR_LOW))
         rd_byte = ptr_ff[LANE_W-1:0];
      else if (is_idx(rd_idx, IDX_ADDR_HIGH))
         rd_byte = LANE_W'(ptr_ff[PTR_W-1:LANE_W]);
      else if (is_idx(rd_idx, IDX_PAT_DATA))
         rd_byte = pat_ff[ptr_ff];
      else if (is_idx(rd_idx, IDX_AUX_CTRL))
         rd_byte = aux_ff;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rvalid_ff <= 1'b0;
      else if (rd_fire)
         rvalid_ff <= 1'b1;
      else if (s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   // data and code are caught at the address edge and stand until rready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_ff <= '0;
      else if (rd_fire)
         rdata_ff <= 32'(rd_byte);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rresp_ff <= RESP_OK;
      else if (rd_fire)
         rresp_ff <= known_idx(rd_idx) ? RESP_OK : RESP_ERR;
   end

   assign aux_ctrl      = crb_aux_t'(aux_ff);
   assign cursor0_color = {color_ff[0], color_ff[1], color_ff[2]};
   assign cursor1_color = {color_ff[3], color_ff[4], color_ff[5]};
   assign cursor_ptr    = ptr_ff;

endmodule : crb_regs

/* dv/crb_regs_checker.sv */
// crb_regs_checker: bus and register assertions on the crb_regs ports
// assumes bind into crb_regs; byte address is four times the index
`timescale 1ns/1ps
module crb_regs_checker
   import crb_pkg::*;
(
   // clock and reset
   input wire logic              aclk, aresetn,
   // write side
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid, s_axi_bready,
   // read side
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [31:0]       s_axi_rdata,
   // register outputs
   input wire crb_aux_t          aux_ctrl,
   input wire crb_color_t        cursor0_color,
   input wire logic [PTR_W-1:0]  cursor_ptr
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_aux_reset:
      assert property ($rose(aresetn) |-> aux_ctrl == AUX_RST) else $error("aux not at reset");
   a_wr_answer:
      assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_rd_answer:
      assert property (s_rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer wrong");
   a_resp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_high_zero:
      assert property ((s_rd_take and s_axi_araddr == 12'h024) |=> s_axi_rdata[7:2] == 6'h00)
      else $error("pointer high byte upper bits set");
   a_ptr_step:
      assert property ((s_rd_take and s_axi_araddr == 12'h028) |=>
                       cursor_ptr == $past(cursor_ptr) + PTR_ONE)
      else $error("pointer did not advance");
   a_ptr_low:
      assert property ((s_wr_take and s_axi_awaddr == 12'h020) |->
                       ##2 cursor_ptr[7:0] == $past(s_axi_wdata[7:0], 2))
      else $error("pointer low byte not loaded");
   a_color_load:
      assert property ((s_wr_take and s_axi_awaddr == 12'h08c) |->
                       ##2 cursor0_color.red == $past(s_axi_wdata[7:0], 2))
      else $error("colour 0 red not loaded");
   a_unmapped_err:
      assert property ((s_wr_take and s_axi_awaddr == 12'h000) |-> ##2 s_axi_bresp == RESP_ERR)
      else $error("unmapped write not refused");
endmodule : crb_regs_checker

bind crb_regs crb_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .aux_ctrl(aux_ctrl),
   .cursor0_color(cursor0_color), .cursor_ptr(cursor_ptr));

/* dv/crb_host.sv */
// crb_host: axi4-lite master standing in for the host processor
// assumes one clock; the bench calls its tasks one at a time
`timescale 1ns/1ps
module crb_host
   import crb_pkg::*;
(
   // clock
   input  wire logic              aclk,
   // write channels
   output logic [ADDR_W-1:0]      awaddr,
   output logic [31:0]            wdata,
   output logic                   awvalid, wvalid, bready,
   input  wire logic              awready, wready, bvalid,
   input  wire logic [1:0]        bresp,
   // read channels
   output logic [ADDR_W-1:0]      araddr,
   output logic                   arvalid, rready,
   input  wire logic              arready, rvalid,
   input  wire logic [31:0]       rdata,
   input  wire logic [1:0]        rresp
);
   initial {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;

   // pointer low byte goes before high byte; the caller keeps pattern bytes in 00-3f
   task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         // released payload is inverted so a stale value never looks valid
         if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
         if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
      end
      while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
      end
      while (!(rvalid && rready));
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : crb_host

/* dv/tb_crb_regs.sv */
// tb_crb_regs: directed register tests of crb_regs through the host model
// assumes host model tasks are called one at a time from here
`timescale 1ns/1ps
module tb_crb_regs
   import crb_pkg::*;
;
   logic              aclk, aresetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, d;
   logic [1:0]        bresp, rresp, r;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   crb_aux_t          aux;
   crb_color_t        c0, c1;
   logic [PTR_W-1:0]  ptr;
   logic [7:0]        cv [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01, 8'h80};
   int                n_mismatch = 0;
   int                checks_done = 0;

   crb_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rresp(rresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_ctrl(aux), .cursor0_color(c0),
      .cursor1_color(c1), .cursor_ptr(ptr));
   crb_host u_host (.aclk, .awaddr, .wdata, .awvalid, .wvalid, .bready, .awready, .wready,
      .bvalid, .bresp, .araddr, .arvalid, .rready, .arready, .rvalid, .rdata, .rresp);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // a full pass takes about a hundred cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      u_host.rd(12'h0a4, d, r);
      chk("aux reset", {24'h0, AUX_RST}, d);
      u_host.wr(12'h0a4, 8'hff, r);
      chk("aux port", 32'hef, {24'h0, aux});
      u_host.rd(12'h0a4, d, r);
      chk("aux read", 32'hef, d);
      for (int i = 0; i < COLOR_NUM; i++)
         u_host.wr(12'h08c + 12'(4 * i), cv[i], r);
      for (int i = 0; i < COLOR_NUM; i++)
      begin
         u_host.rd(12'h08c + 12'(4 * i), d, r);
         chk("colour byte", {24'h0, cv[i]}, d);
      end
      chk("colour 0", {8'h0, cv[0], cv[1], cv[2]}, {8'h0, c0});
      chk("colour 1", {8'h0, cv[3], cv[4], cv[5]}, {8'h0, c1});
      u_host.wr(12'h020, 8'hff, r);
      u_host.wr(12'h024, 8'hff, r);
      chk("pointer", 32'h3ff, {22'h0, ptr});
      u_host.rd(12'h024, d, r);
      chk("pointer high", 32'h03, d);
      u_host.wr(12'h028, 8'h39, r);
      chk("pointer wrap", 32'h0, {22'h0, ptr});
      u_host.wr(12'h028, 8'h2a, r);
      u_host.wr(12'h020, 8'hff, r);
      u_host.wr(12'h024, 8'h03, r);
      u_host.rd(12'h028, d, r);
      chk("pattern 3ff", 32'h39, d);
      u_host.rd(12'h028, d, r);
      chk("pattern 000", 32'h2a, d);
      chk("pointer step", 32'h1, {22'h0, ptr});
      u_host.wr(12'h000, 8'h11, r);
      chk("unmapped write", {30'h0, RESP_ERR}, {30'h0, r});
      u_host.rd(12'h02c, d, r);
      chk("unmapped read", {30'h0, RESP_ERR}, {30'h0, r});
      finish_test();
   end
endmodule : tb_crb_regs
